// >>> rtl/t2e_reply_sel.sv
// Reply selector for tag READ, WRITE and SECTOR SELECT frames
//
// Contract
// [RULE1] Parity or CRC error: silent when option 0, NAK 1 when 1; then sleep.
// [RULE2] Malformed frames: silent and sleep regardless of the option.
// [RULE3] Read fully protected: NAK 4; partly protected: protected bytes read zero.
// [RULE4] Read range absent: NAK 0; partly absent: missing bytes read zero.
// [RULE5] Write locked or absent: NAK 0; protected: NAK 4; collision: NAK 5.
// [RULE6] Short or data-less write: silent sleep; good write: ACK, stay selected.
// [RULE7] Reader waits for an empty buffer before writing EEPROM; the testbench writes EEPROM while busy_q is set.
// [RULE8] EEPROM write during a buffer transfer succeeds, buffer is dropped.
// [RULE9] Status flags readable anytime without disturbing a transfer.
// [RULE10] Busy and ready flags shown in buffer status register 1.
// [RULE11] Rx start in interrupt register 1; rx and tx end in register 0.
// [RULE12] Buffer write while either ready flag set: NAK 0 and sleep; code ACKs a zero-data BUF_LAST write while iordy_q set, busy_q clear.
// [RULE13] Buffer write starting past the first mailbox block: NAK 0, sleep.
// [RULE14] Reply policy bit sampled at frame end.
`timescale 1ns/1ns
module t2e_reply_sel
    import t2e_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         resetn,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    output logic              irq,
    input  wire logic         frame_end,
    input  wire logic [1:0]   frame_cmd,
    input  wire logic [7:0]   frame_addr,
    input  wire logic         err_parity,
    input  wire logic         err_crc,
    input  wire logic         frame_malformed,
    input  wire logic         wr_data_zero,
    input  wire logic [15:0]  byte_exists,
    input  wire logic [15:0]  byte_protected,
    input  wire logic         write_locked,
    input  wire logic         eeprom_collision,
    input  wire logic         buffer_collision,
    input  wire logic [127:0] mem_data,
    input  wire logic         reselect,
    output logic              reply_valid,
    output logic      [1:0]   reply_kind,
    output logic      [3:0]   reply_nak,
    output logic      [127:0] reply_data,
    output logic              tag_selected,
    output logic              buf_store,
    output logic              buf_discard
);
    logic [1:0]     cfg_q;
    logic           busy_q;
    logic           rfrdy_q;
    logic           iordy_q;
    logic [1:0]     i0st_q;
    logic [1:0]     i0en_q;
    logic           i1st_q;
    logic           i1en_q;
    t2e_tag_state_t tag_q;
    logic [127:0]   masked;
    logic [127:0]   bufrep;
    logic [31:0]    rd_val;
    logic           wr_stb;
    logic           nak_on;
    logic           ext_on;
    logic           is_buf;
    logic           mcu_tx;
    logic           mcu_clr;
    // Decision outputs
    logic [1:0]     d_kind;
    logic [3:0]     d_nak;
    logic [127:0]   d_data;
    logic           d_sleep;
    logic           d_busy_set;
    logic           d_busy_clr;
    logic           d_rfrdy_set;
    logic           d_iordy_clr;
    logic           d_rxs;
    logic           d_rxe;
    logic           d_txe;
    logic           d_store;
    logic           d_discard;

    assign nak_on = cfg_q[CFG_NAK_BIT];
    assign ext_on = cfg_q[CFG_EXT_BIT];
    assign is_buf = ext_on && (frame_addr >= BUF_FIRST);
    assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign mcu_tx = wr_stb && (wb_adr_i == OFS_CMD) && wb_dat_i[CMD_TX_BIT];
    assign mcu_clr = wr_stb && (wb_adr_i == OFS_CMD) && wb_dat_i[CMD_CLR_BIT];

    // Per byte: absent or protected bytes read as zero
    for (genvar i = 0; i < 16; i++)
    begin : g_mask
        assign masked[8*i +: 8] = (byte_exists[i] && !byte_protected[i])
                                  ? mem_data[8*i +: 8] : 8'h00; // [RULE3] [RULE4]
    end

    // Mailbox reply: 12 data bytes, 3 zero, then flags (busy, ready)
    assign bufrep = iordy_q ? {6'h00, 1'b0, 1'b1, 24'h000000, mem_data[95:0]}
                            : {6'h00, 1'b1, 1'b0, 120'h0};

    // Reply choice for the frame that ends this cycle
    always_comb
    begin
        d_kind = RK_NONE;
        d_nak = NAK_0;
        d_data = masked;
        d_sleep = 1'b1;
        d_busy_set = 1'b0;
        d_busy_clr = 1'b0;
        d_rfrdy_set = 1'b0;
        d_iordy_clr = 1'b0;
        d_rxs = 1'b0;
        d_rxe = 1'b0;
        d_txe = 1'b0;
        d_store = 1'b0;
        d_discard = 1'b0;
        if (frame_malformed)
        begin
            d_kind = RK_NONE; // [RULE2] [RULE6]
        end
        else if (err_parity || err_crc)
        begin
            // Option read right at frame end [RULE14]
            d_kind = nak_on ? RK_NAK : RK_NONE; // [RULE1]
            d_nak = NAK_1;
        end
        else
        begin
            case (frame_cmd)
                CMD_READ:
                begin
                    if (is_buf)
                    begin
                        if (frame_addr != BUF_FIRST)
                            d_kind = RK_NAK;
                        else if (buffer_collision)
                        begin
                            d_kind = RK_NAK;
                            d_nak = NAK_5;
                        end
                        else
                        begin
                            d_kind = RK_DATA;
                            d_data = bufrep;
                            d_sleep = 1'b0;
                        end
                    end
                    else if (eeprom_collision)
                    begin
                        d_kind = RK_NAK;
                        d_nak = NAK_5; // [RULE5]
                    end
                    else if (byte_exists == 16'h0000)
                        d_kind = RK_NAK; // [RULE4]
                    else if ((byte_protected | ~byte_exists) == 16'hffff)
                    begin
                        d_kind = RK_NAK;
                        d_nak = NAK_4; // [RULE3]
                    end
                    else
                    begin
                        d_kind = RK_DATA;
                        d_sleep = 1'b0;
                    end
                end
                CMD_WRITE:
                begin
                    if (is_buf)
                    begin
                        if (buffer_collision)
                        begin
                            d_kind = RK_NAK;
                            d_nak = NAK_5;
                        end
                        else if (frame_addr == BUF_LAST && !busy_q && iordy_q)
                        begin
                            // Reader clears the buffer after reading it
                            d_kind = wr_data_zero ? RK_ACK : RK_NAK;
                            d_sleep = !wr_data_zero;
                            d_iordy_clr = wr_data_zero;
                            d_txe = wr_data_zero;
                        end
                        else if (iordy_q || rfrdy_q)
                            d_kind = RK_NAK; // [RULE12]
                        else if (frame_addr != BUF_FIRST && !busy_q)
                            d_kind = RK_NAK; // [RULE13]
                        else
                        begin
                            d_kind = RK_ACK;
                            d_sleep = 1'b0;
                            d_store = 1'b1;
                            d_busy_set = (frame_addr == BUF_FIRST);
                            d_rxs = (frame_addr == BUF_FIRST);
                            d_busy_clr = (frame_addr == BUF_LAST);
                            d_rfrdy_set = (frame_addr == BUF_LAST);
                            d_rxe = (frame_addr == BUF_LAST);
                        end
                    end
                    else if (eeprom_collision)
                    begin
                        d_kind = RK_NAK;
                        d_nak = NAK_5; // [RULE5]
                    end
                    else if (!byte_exists[0] || write_locked)
                        d_kind = RK_NAK; // [RULE5]
                    else if (byte_protected[0])
                    begin
                        d_kind = RK_NAK;
                        d_nak = NAK_4; // [RULE5]
                    end
                    else
                    begin
                        d_kind = RK_ACK; // [RULE6]
                        d_sleep = 1'b0;
                        // Interleaved transfer loses the buffer [RULE8]
                        d_discard = busy_q;
                        d_busy_clr = busy_q;
                    end
                end
                CMD_SSEL:
                    d_kind = RK_NAK;
                default:
                    d_kind = RK_NONE;
            endcase
        end
    end

    // Reply outputs, one pulse per frame
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            reply_valid <= 1'b0;
            reply_kind <= RK_NONE;
            reply_nak <= NAK_0;
            reply_data <= 128'h0;
            buf_store <= 1'b0;
            buf_discard <= 1'b0;
        end
        else
        begin
            reply_valid <= frame_end;
            reply_kind <= frame_end ? d_kind : RK_NONE;
            reply_nak <= frame_end ? d_nak : NAK_0;
            reply_data <= (frame_end && d_kind == RK_DATA) ? d_data : 128'h0;
            buf_store <= frame_end && d_store;
            buf_discard <= frame_end && d_discard;
        end
    end

    // Tag state: sleeps on error replies, anticollision reselects
    always_ff @(posedge clock)
    begin
        if (!resetn)
            tag_q <= TS_SLEEP;
        else if (frame_end)
            tag_q <= d_sleep ? TS_SLEEP : TS_SELECTED;
        else if (reselect)
            tag_q <= TS_SELECTED;
    end
    assign tag_selected = (tag_q == TS_SELECTED);

    // Exchange buffer flags; a set beats a same-cycle clear
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            busy_q <= 1'b0;
            rfrdy_q <= 1'b0;
            iordy_q <= 1'b0;
        end
        else
        begin
            busy_q <= (frame_end && d_busy_set)
                      || (busy_q && !(frame_end && d_busy_clr));
            rfrdy_q <= (frame_end && d_rfrdy_set) || (rfrdy_q && !mcu_clr);
            iordy_q <= mcu_tx || (iordy_q && !(frame_end && d_iordy_clr));
        end
    end

    // Sticky interrupts, set wins over write-one clear [RULE11]
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            i0st_q <= I0_RST;
            i1st_q <= I1_RST;
        end
        else
        begin
            i0st_q[I0_RXE_BIT] <= (frame_end && d_rxe) || (i0st_q[I0_RXE_BIT]
                && !(wr_stb && wb_adr_i == OFS_I0CLR && wb_dat_i[I0_RXE_BIT]));
            i0st_q[I0_TXE_BIT] <= (frame_end && d_txe) || (i0st_q[I0_TXE_BIT]
                && !(wr_stb && wb_adr_i == OFS_I0CLR && wb_dat_i[I0_TXE_BIT]));
            i1st_q <= (frame_end && d_rxs) || (i1st_q
                && !(wr_stb && wb_adr_i == OFS_I1CLR && wb_dat_i[I1_RXS_BIT]));
        end
    end

    // Software written configuration and enables
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            cfg_q <= CFG_RST;
            i0en_q <= I0_RST;
            i1en_q <= I1_RST;
        end
        else if (wr_stb)
        begin
            if (wb_adr_i == OFS_CFG)
                cfg_q <= wb_dat_i[1:0];
            if (wb_adr_i == OFS_I0EN)
                i0en_q <= wb_dat_i[1:0];
            if (wb_adr_i == OFS_I1EN)
                i1en_q <= wb_dat_i[0];
        end
    end

    // Level interrupt, one cycle behind the status bits
    always_ff @(posedge clock)
    begin
        if (!resetn)
            irq <= 1'b0;
        else
            irq <= |(i0st_q & i0en_q) || (i1st_q && i1en_q);
    end

    // Read mux; reads have no side effects [RULE9]
    always_comb
    begin
        rd_val = 32'h0;
        case (wb_adr_i)
            OFS_CFG:  rd_val = {30'h0, cfg_q};
            OFS_BST1: rd_val = {29'h0, iordy_q, rfrdy_q, busy_q}; // [RULE10]
            OFS_I0ST: rd_val = {30'h0, i0st_q};
            OFS_I0EN: rd_val = {30'h0, i0en_q};
            OFS_I1ST: rd_val = {31'h0, i1st_q};
            OFS_I1EN: rd_val = {31'h0, i1en_q};
            default:  rd_val = 32'h0;
        endcase
    end

    // Wishbone slave: one wait state, unmapped reads give zero
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= (wb_cyc_i && wb_stb_i && !wb_we_i) ? rd_val : 32'h0;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    AST_ERR_SILENT: assert property (frame_end && !frame_malformed && err_crc && !nak_on // [RULE1]
        |=> reply_kind == RK_NONE && !tag_selected) else $error("crc error not silent");
    AST_ERR_NAK1: assert property (frame_end && !frame_malformed && err_parity && nak_on // [RULE1]
        |=> reply_kind == RK_NAK && reply_nak == NAK_1) else $error("parity error no NAK 1");
    AST_MALFORMED: assert property (frame_end && frame_malformed // [RULE2]
        |=> reply_valid && reply_kind == RK_NONE && !tag_selected) else $error("malformed answered");
    AST_PROT_READ: assert property (frame_end && !frame_malformed && !err_crc && !err_parity
        && frame_cmd == CMD_READ && !is_buf && !eeprom_collision && byte_exists != 16'h0 // [RULE3]
        && byte_protected == 16'hffff |=> reply_nak == NAK_4) else $error("protected read no NAK 4");
    AST_ABSENT_READ: assert property (frame_end && !frame_malformed && !err_crc && !err_parity
        && frame_cmd == CMD_READ && !is_buf && !eeprom_collision && byte_exists == 16'h0 // [RULE4]
        |=> reply_kind == RK_NAK && reply_nak == NAK_0) else $error("absent read no NAK 0");
    AST_COLLIDE: assert property (frame_end && !frame_malformed && !err_crc && !err_parity
        && frame_cmd == CMD_WRITE && !is_buf && eeprom_collision // [RULE5]
        |=> reply_nak == NAK_5 ##1 !tag_selected || reply_valid) else $error("collision no NAK 5");
    AST_DISCARD: assert property (buf_discard |-> !busy_q && reply_kind == RK_ACK // [RULE8]
        && $past(busy_q)) else $error("discard without busy buffer");
    AST_FULL_NAK: assert property (frame_end && !frame_malformed && !err_crc && !err_parity
        && frame_cmd == CMD_WRITE && is_buf && !buffer_collision && rfrdy_q // [RULE12]
        |=> reply_kind == RK_NAK && reply_nak == NAK_0 && rfrdy_q) else $error("full buffer accepted");
    AST_RXS_IRQ: assert property ($rose(i1st_q) && i1en_q |=> irq) // [RULE11]
        else $error("rx start interrupt missing");

    COV_BUF_IN: cover property (frame_end && d_rxs ##[1:50] frame_end && d_rxe);
    COV_BUF_OUT: cover property (mcu_tx ##[1:50] frame_end && d_txe);
    COV_NAK1: cover property (reply_valid && reply_nak == NAK_1 && reply_kind == RK_NAK);
endmodule

// >>> rtl/t2e_pkg.sv
// Constants and types for the tag reply selector
package t2e_pkg;
    // Frame command classes from the frame decoder
    localparam logic [1:0] CMD_READ  = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_SSEL  = 2'h2;
    localparam logic [1:0] CMD_OTHER = 2'h3;
    // Reply kinds
    localparam logic [1:0] RK_NONE = 2'h0;
    localparam logic [1:0] RK_NAK  = 2'h1;
    localparam logic [1:0] RK_ACK  = 2'h2;
    localparam logic [1:0] RK_DATA = 2'h3;
    // NAK codes
    localparam logic [3:0] NAK_0 = 4'h0;
    localparam logic [3:0] NAK_1 = 4'h1;
    localparam logic [3:0] NAK_4 = 4'h4;
    localparam logic [3:0] NAK_5 = 4'h5;
    // Mailbox blocks
    localparam logic [7:0] BUF_FIRST = 8'hfc;
    localparam logic [7:0] BUF_LAST  = 8'hff;
    // Register offsets
    localparam logic [7:0] OFS_CFG   = 8'h00;
    localparam logic [7:0] OFS_CMD   = 8'h04;
    localparam logic [7:0] OFS_BST1  = 8'h08;
    localparam logic [7:0] OFS_I0ST  = 8'h0c;
    localparam logic [7:0] OFS_I0CLR = 8'h10;
    localparam logic [7:0] OFS_I0EN  = 8'h14;
    localparam logic [7:0] OFS_I1ST  = 8'h18;
    localparam logic [7:0] OFS_I1CLR = 8'h1c;
    localparam logic [7:0] OFS_I1EN  = 8'h20;
    // Field positions
    localparam int CFG_NAK_BIT = 0;
    localparam int CFG_EXT_BIT = 1;
    localparam int CMD_TX_BIT  = 0;
    localparam int CMD_CLR_BIT = 1;
    localparam int I0_RXE_BIT  = 0;
    localparam int I0_TXE_BIT  = 1;
    localparam int I1_RXS_BIT  = 0;
    // Reset values
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic [1:0] I0_RST  = 2'h0;
    localparam logic       I1_RST  = 1'h0;
    // Tag protocol state
    typedef enum logic {TS_SLEEP, TS_SELECTED} t2e_tag_state_t;
endpackage

// >>> testbench/t2e_reader_model.sv
// Reader-side model that delivers decoded frames to the reply selector
`timescale 1ns/1ns
module t2e_reader_model
    import t2e_pkg::*;
#(
    parameter logic [127:0] MEM = 128'h0
)
(
    input  wire logic         clock,
    output logic              frame_end,
    output logic      [1:0]   frame_cmd,
    output logic      [7:0]   frame_addr,
    output logic              err_parity,
    output logic              err_crc,
    output logic              frame_malformed,
    output logic              wr_data_zero,
    output logic      [15:0]  byte_exists,
    output logic      [15:0]  byte_protected,
    output logic              write_locked,
    output logic              eeprom_collision,
    output logic      [127:0] mem_data,
    output logic              reselect
);
    // Quiet lines at time zero
    initial
    begin
        frame_end = 1'b0;
        reselect  = 1'b0;
        {frame_cmd, frame_addr, err_parity, err_crc, frame_malformed} = '0;
        {wr_data_zero, byte_exists, byte_protected, write_locked, eeprom_collision, mem_data} = '0;
    end

    // One frame; f = {parity, crc, malformed, zero data, locked, collision}
    // Caller does not wait for an empty mailbox before EEPROM writes in extended mode
    task automatic send(input logic r, input logic [1:0] c, input logic [7:0] a,
                        input logic [5:0] f, input logic [15:0] ex, input logic [15:0] pr);
        @(posedge clock);
        reselect <= r;
        @(posedge clock);
        reselect <= 1'b0;
        frame_end <= 1'b1;
        frame_cmd <= c;
        frame_addr <= a;
        {err_parity, err_crc, frame_malformed, wr_data_zero, write_locked, eeprom_collision} <= f;
        byte_exists <= ex;
        byte_protected <= pr;
        mem_data <= MEM;
        @(posedge clock);
        // Released lines flip so stale values never look valid
        frame_end <= 1'b0;
        frame_cmd <= ~c;
        frame_addr <= ~a;
        {err_parity, err_crc, frame_malformed, wr_data_zero, write_locked, eeprom_collision} <= ~f;
        byte_exists <= ~ex;
        byte_protected <= ~pr;
        mem_data <= ~MEM;
    endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking testbench for the tag reply selector
`timescale 1ns/1ns
module testbench;
    import t2e_pkg::*;
    localparam logic [127:0] MEM = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
    typedef struct packed {
        logic [1:0]  cmd;
        logic        nak;
        logic [5:0]  f;
        logic [15:0] ex;
        logic [15:0] pr;
        logic [1:0]  kind;
        logic [3:0]  code;
        logic        sel;
    } t2e_row_t;
    logic         clock, resetn, cyc, stb, we, wb_ack_o, irq, reply_valid, tag_selected;
    logic         buf_store, buf_discard, frame_end, err_parity, err_crc, frame_malformed;
    logic         wr_data_zero, write_locked, eeprom_collision, reselect, buf_coll;
    logic [7:0]   adr, frame_addr;
    logic [31:0]  wdat, wb_dat_o, rd;
    logic [1:0]   frame_cmd, reply_kind;
    logic [3:0]   reply_nak;
    logic [15:0]  byte_exists, byte_protected;
    logic [127:0] mem_data, reply_data;
    int           error_cnt, compares;
    t2e_row_t     rows [15];

    t2e_reader_model #(.MEM(MEM)) rdr (.clock, .frame_end, .frame_cmd, .frame_addr, .err_parity,
        .err_crc, .frame_malformed, .wr_data_zero, .byte_exists, .byte_protected, .write_locked,
        .eeprom_collision, .mem_data, .reselect);
    t2e_reply_sel dut (.clock, .resetn, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .irq, .frame_end, .frame_cmd,
        .frame_addr, .err_parity, .err_crc, .frame_malformed, .wr_data_zero, .byte_exists,
        .byte_protected, .write_locked, .eeprom_collision, .buffer_collision(buf_coll), .mem_data,
        .reselect, .reply_valid, .reply_kind, .reply_nak, .reply_data, .tag_selected, .buf_store,
        .buf_discard);

    // 250 MHz clock
    always #2 clock = ~clock;

    task automatic results;
        $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk_val(input logic [127:0] g, input logic [127:0] e);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Reply seen in the cycle after frame_end
    task automatic chk_reply(input logic [1:0] k, input logic [3:0] c, input logic s);
        #1;
        chk_val({reply_valid, reply_kind, tag_selected}, {1'b1, k, s});
        if (k == RK_NAK)
            chk_val(reply_nak, c);
    endtask

    // Classic single Wishbone cycle; waits for ack with a bound
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        @(posedge clock);
        while (wb_ack_o !== 1'b1 && n < 100)
        begin
            @(posedge clock);
            n++;
        end
        rd = wb_dat_o;
        {cyc, stb} <= 2'b00;
        if (n == 100)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: no bus acknowledge", $time);
        end
    endtask

    task automatic rdreg(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk_val(rd, e);
    endtask

    // Expected read data: only existing, unprotected bytes survive
    function automatic logic [127:0] keep(input logic [15:0] ex, input logic [15:0] pr);
        logic [127:0] k;
        for (int i = 0; i < 16; i++)
            k[8*i +: 8] = (ex[i] && !pr[i]) ? MEM[8*i +: 8] : 8'h00;
        return k;
    endfunction

    task automatic data_rd(input logic [5:0] f, input logic [15:0] ex, input logic [15:0] pr);
        rdr.send(1'b1, CMD_READ, 8'h04, f, ex, pr);
        chk_reply(RK_DATA, NAK_0, 1'b1);
        chk_val(reply_data, keep(ex, pr));
    endtask

    // Hang guard: whole run is far shorter
    initial
    begin
        #100000;
        error_cnt++;
        results();
    end

    initial
    begin
        {clock, resetn, cyc, stb, we, adr, wdat, buf_coll} = '0;
        error_cnt = 0;
        compares = 0;
        rows[0]  = '{CMD_READ,  1'b0, 6'h30, 16'hffff, 16'h0000, RK_NONE, NAK_0, 1'b0};
        rows[1]  = '{CMD_READ,  1'b1, 6'h10, 16'hffff, 16'h0000, RK_NAK,  NAK_1, 1'b0};
        rows[2]  = '{CMD_SSEL,  1'b1, 6'h20, 16'hffff, 16'h0000, RK_NAK,  NAK_1, 1'b0};
        rows[3]  = '{CMD_WRITE, 1'b1, 6'h08, 16'hffff, 16'h0000, RK_NONE, NAK_0, 1'b0};
        rows[4]  = '{CMD_READ,  1'b1, 6'h38, 16'hffff, 16'h0000, RK_NONE, NAK_0, 1'b0};
        rows[5]  = '{CMD_READ,  1'b0, 6'h00, 16'hffff, 16'hffff, RK_NAK,  NAK_4, 1'b0};
        rows[6]  = '{CMD_READ,  1'b0, 6'h00, 16'h0000, 16'h0000, RK_NAK,  NAK_0, 1'b0};
        rows[7]  = '{CMD_WRITE, 1'b0, 6'h02, 16'hffff, 16'h0000, RK_NAK,  NAK_0, 1'b0};
        rows[8]  = '{CMD_WRITE, 1'b0, 6'h00, 16'h0000, 16'h0000, RK_NAK,  NAK_0, 1'b0};
        rows[9]  = '{CMD_WRITE, 1'b0, 6'h00, 16'hffff, 16'hffff, RK_NAK,  NAK_4, 1'b0};
        rows[10] = '{CMD_WRITE, 1'b1, 6'h01, 16'hffff, 16'h0000, RK_NAK,  NAK_5, 1'b0};
        rows[11] = '{CMD_READ,  1'b0, 6'h01, 16'hffff, 16'h0000, RK_NAK,  NAK_5, 1'b0};
        rows[12] = '{CMD_WRITE, 1'b0, 6'h00, 16'hffff, 16'h0000, RK_ACK,  NAK_0, 1'b1};
        rows[13] = '{CMD_SSEL,  1'b0, 6'h00, 16'hffff, 16'h0000, RK_NAK,  NAK_0, 1'b0};
        rows[14] = '{CMD_OTHER, 1'b1, 6'h00, 16'hffff, 16'h0000, RK_NONE, NAK_0, 1'b0};
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        #1;
        chk_val({irq, reply_valid, tag_selected, buf_store, buf_discard}, 5'h00);
        rdreg(OFS_CFG, {30'h0, CFG_RST});
        rdreg(OFS_BST1, 32'h0);
        rdreg(OFS_I0ST, {30'h0, I0_RST});
        wb(1'b1, 8'h40, 32'hffff_ffff);
        rdreg(8'h40, 32'h0);
        $display("test reset done");
        // Policy bit rewritten before each frame
        foreach (rows[i])
        begin
            wb(1'b1, OFS_CFG, {31'h0, rows[i].nak});
            rdr.send(1'b1, rows[i].cmd, 8'h04, rows[i].f, rows[i].ex, rows[i].pr);
            chk_reply(rows[i].kind, rows[i].code, rows[i].sel);
        end
        $display("test table done");
        data_rd(6'h00, 16'hffff, 16'h00ff);
        data_rd(6'h02, 16'hffff, 16'h0000);
        data_rd(6'h00, 16'h00ff, 16'h0000);
        $display("test read data done");
        // Extended mode mailbox traffic
        wb(1'b1, OFS_CFG, 32'h2);
        rdr.send(1'b1, CMD_WRITE, BUF_FIRST + 8'h1, 6'h00, 16'hffff, 16'h0000);
        chk_reply(RK_NAK, NAK_0, 1'b0);
        rdr.send(1'b1, CMD_WRITE, BUF_FIRST, 6'h00, 16'hffff, 16'h0000);
        chk_reply(RK_ACK, NAK_0, 1'b1);
        chk_val(buf_store, 1'b1);
        rdreg(OFS_BST1, 32'h1);
        rdreg(OFS_I1ST, 32'h1);
        rdr.send(1'b0, CMD_WRITE, 8'h04, 6'h00, 16'hffff, 16'h0000);
        chk_reply(RK_ACK, NAK_0, 1'b1);
        chk_val(buf_discard, 1'b1);
        rdreg(OFS_BST1, 32'h0);
        for (int a = 0; a < 4; a++)
        begin
            rdr.send(1'b0, CMD_WRITE, BUF_FIRST + 8'(a), 6'h00, 16'hffff, 16'h0000);
            chk_reply(RK_ACK, NAK_0, 1'b1);
            if (a == 1)
                rdreg(OFS_BST1, 32'h1);
        end
        rdreg(OFS_BST1, 32'h2);
        rdreg(OFS_I0ST, 32'h1);
        chk_val(irq, 1'b0);
        wb(1'b1, OFS_I0EN, 32'h1);
        repeat (2) @(posedge clock);
        #1 chk_val(irq, 1'b1);
        wb(1'b1, OFS_I0CLR, 32'h1);
        wb(1'b1, OFS_I1CLR, 32'h1);
        repeat (2) @(posedge clock);
        #1 chk_val(irq, 1'b0);
        rdreg(OFS_I1ST, 32'h0);
        rdr.send(1'b0, CMD_WRITE, BUF_FIRST, 6'h00, 16'hffff, 16'h0000);
        chk_reply(RK_NAK, NAK_0, 1'b0);
        wb(1'b1, OFS_CMD, 32'h2);
        rdreg(OFS_BST1, 32'h0);
        $display("test mailbox write done");
        rdr.send(1'b1, CMD_READ, BUF_FIRST, 6'h00, 16'hffff, 16'h0000);
        chk_reply(RK_DATA, NAK_0, 1'b1);
        chk_val(reply_data, {8'h02, 120'h0});
        rdr.send(1'b0, CMD_WRITE, 8'h04, 6'h00, 16'hffff, 16'h0000);
        chk_reply(RK_ACK, NAK_0, 1'b1);
        chk_val(buf_discard, 1'b0);
        wb(1'b1, OFS_CMD, 32'h1);
        rdreg(OFS_BST1, 32'h4);
        rdr.send(1'b0, CMD_READ, BUF_FIRST, 6'h00, 16'hffff, 16'h0000);
        chk_reply(RK_DATA, NAK_0, 1'b1);
        chk_val(reply_data, {8'h01, 24'h0, MEM[95:0]});
        rdr.send(1'b0, CMD_WRITE, BUF_LAST, 6'h04, 16'hffff, 16'h0000);
        chk_reply(RK_ACK, NAK_0, 1'b1);
        rdreg(OFS_I0ST, 32'h2);
        // Rx start reaches the interrupt line once enabled
        wb(1'b1, OFS_I1EN, 32'h1);
        rdr.send(1'b0, CMD_WRITE, BUF_FIRST, 6'h00, 16'hffff, 16'h0000);
        chk_reply(RK_ACK, NAK_0, 1'b1);
        @(posedge clock);
        #1 chk_val(irq, 1'b1);
        // Mailbox read that collides with the host side
        buf_coll <= 1'b1;
        rdr.send(1'b0, CMD_READ, BUF_FIRST, 6'h00, 16'hffff, 16'h0000);
        chk_reply(RK_NAK, NAK_5, 1'b0);
        buf_coll <= 1'b0;
        $display("test mailbox read done");
        results();
    end
endmodule
